// ---- bench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ucg_regs.vh"
module tb;
   typedef struct {logic [3:0] c; logic [11:0] d; logic pe; logic [3:0] m; logic [31:0] tp, rp, lp;} ucg_row_t;
   logic CLOCK, RST, PSEL, PENABLE, PWRITE, peer_en, peer_clk, xck_pin, er;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, rd, p, q;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, XCK_OUT, XCK_OE_N, TX_TICK, RX_TICK, RX_LAST_PHASE;
   wire [3:0] MODE, RX_PHASE;
   int fails, comparisons, cyc, i, k;
   // ------------------------------------------------------------
   // Rows: control, divisor, peer on, mode, transmit, receive and wrap periods
   // ------------------------------------------------------------
   // Rows 3 and 5 set double speed in sync modes on purpose, to show that it is ignored there.
   // Rows 4 and 5 share one polarity, so no change edge is repeated when the divisor drops to zero.
   ucg_row_t rows[6] = '{'{4'h0, 12'h002, 1'b1, 4'h1, 48, 3, 48}, '{4'h2, 12'h002, 1'b1, 4'h2, 24, 3, 24},
      '{4'h1, 12'h000, 1'b1, 4'h8, 8, 8, 2}, '{4'h3, 12'h000, 1'b1, 4'h8, 8, 8, 2},
      '{4'hd, 12'h003, 1'b0, 4'h4, 8, 8, 8}, '{4'hf, 12'h000, 1'b0, 4'h4, 2, 2, 2}};
   // The design owns the pin while enabled, otherwise the peer's clock reaches it.
   assign xck_pin = !XCK_OE_N ? XCK_OUT : peer_clk;
   ucg_clock_gen i_ucg_clock_gen (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .XCK_IN(xck_pin),
      .XCK_OUT(XCK_OUT), .XCK_OE_N(XCK_OE_N), .MODE(MODE), .TX_TICK(TX_TICK), .RX_TICK(RX_TICK),
      .RX_PHASE(RX_PHASE), .RX_LAST_PHASE(RX_LAST_PHASE));
   ucg_peer i_ucg_peer (.CLOCK(CLOCK), .RST(RST), .en(peer_en), .clk_out(peer_clk));
   // Clock and a hang limit well above the expected run length.
   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         final_report;
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // APB transfer; read data and error are taken at the edge that sees ready.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, {31'h0, e});
   endtask
   // The high byte waits for the low byte write, so it goes first.
   task automatic setdiv(input logic [11:0] v);
      apb(1'b1, `UCG_OFF_DIV_HIGH, {28'h0, v[11:8]});
      apb(1'b1, `UCG_OFF_DIV_LOW, {24'h0, v[7:0]});
   endtask
   function automatic logic sig(input int s);
      return s == 0 ? TX_TICK : (s == 1 ? RX_TICK : RX_LAST_PHASE);
   endfunction
   // Wait for one pulse (cycles in q), then count the cycles to the next (in p).
   task automatic per(input int s);
      @(posedge CLOCK);
      for (q = 0; q < 9000 && sig(s) !== 1'b1; q++) @(posedge CLOCK);
      p = 0;
      do begin
         @(posedge CLOCK);
         p++;
      end while (sig(s) !== 1'b1 && p < 9000);
   endtask
   task final_report;
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {RST, PSEL, PENABLE, PWRITE, peer_en} = 5'b10000;
      PADDR = 12'h0;
      PWDATA = 32'h0;
      repeat (10) @(posedge CLOCK);
      RST <= 1'b0;
      rdchk(`UCG_OFF_CTRL, 32'h0, 1'b0);
      rdchk(`UCG_OFF_DIV_LOW, 32'h0, 1'b0);
      chk({26'h0, MODE, XCK_OE_N, XCK_OUT}, {26'h0, 4'h1, 2'b10});
      // Every mode; the peer runs during the asynchronous rows and must go unseen.
      for (i = 0; i < 6; i++) begin
         peer_en <= rows[i].pe;
         setdiv(rows[i].d);
         apb(1'b1, `UCG_OFF_CTRL, {28'h0, rows[i].c});
         for (k = 0; k < 3; k++) begin
            per(k);
            per(k);
            chk(p, k == 0 ? rows[i].tp : (k == 1 ? rows[i].rp : rows[i].lp));
         end
         chk({28'h0, RX_PHASE}, rows[i].m == 4'h1 ? 32'hf : (rows[i].m == 4'h2 ? 32'h7 : 32'h1));
         chk({28'h0, MODE}, {28'h0, rows[i].m});
      end
      // Polarity decides which pin edge carries the transmit tick; a slow divisor keeps the
      // change edges of the old and the new polarity out of adjacent cycles.
      setdiv(12'h003);
      for (k = 0; k < 2; k++) begin
         apb(1'b1, `UCG_OFF_CTRL, {28'h0, k[0], 3'b101});
         per(0);
         per(0);
         chk({31'h0, XCK_OUT}, {31'h0, ~k[0]});
      end
      // A low byte write cuts a long count short at once.
      setdiv(12'hfa0);
      apb(1'b1, `UCG_OFF_CTRL, 32'h0);
      repeat (20) @(posedge CLOCK);
      setdiv(12'h002);
      per(1);
      chk({31'h0, q < 8}, 32'h1);
      // Widest divisor, then a lone high write that must not apply yet.
      setdiv(12'hfff);
      per(1);
      per(1);
      chk(p, 32'd4096);
      rdchk(`UCG_OFF_DIV_LOW, 32'hff, 1'b0);
      apb(1'b1, `UCG_OFF_DIV_HIGH, 32'h0);
      rdchk(`UCG_OFF_DIV_HIGH, 32'h0, 1'b0);
      per(1);
      chk(p, 32'd4096);
      // Unmapped read and a write to the read-only place.
      rdchk(12'h010, 32'h0, 1'b1);
      apb(1'b1, `UCG_OFF_STATUS, 32'hffff_ffff);
      chk({31'h0, er}, 32'h0);
      // Reset in mid-run from master mode.
      apb(1'b1, `UCG_OFF_CTRL, 32'h5);
      repeat (3) @(posedge CLOCK);
      RST <= 1'b1;
      @(posedge CLOCK);
      @(posedge CLOCK);
      chk({20'h0, RX_PHASE, TX_TICK, RX_TICK, MODE, XCK_OE_N, XCK_OUT}, {20'h0, 4'h0, 2'b00, 4'h1, 2'b10});
      RST <= 1'b0;
      rdchk(`UCG_OFF_CTRL, 32'h0, 1'b0);
      final_report;
   end
endmodule // tb
`default_nettype wire

// ---- bench/ucg_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks for the clock generator
// ------------------------------------------------------------
module ucg_asserts (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic [11:0] PADDR,
   input wire logic PSLVERR,
   input wire logic XCK_IN,
   input wire logic XCK_OUT,
   input wire logic XCK_OE_N,
   input wire logic [3:0] MODE,
   input wire logic TX_TICK,
   input wire logic RX_TICK
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   wire any_tick = TX_TICK | RX_TICK;
   wire bad_addr = (PADDR > 12'h00c) || (PADDR[1:0] != 2'h0);
   wire master3 = (MODE == 4'h4);
   // Master checks wait three cycles in the mode so slave ticks still in flight are not judged.
   sequence s_master;
      master3 && $past(MODE) == 4'h4 && $past(MODE, 3) == 4'h4;
   endsequence
   sequence s_xck_edge;
      (MODE == 4'h8 && $changed(XCK_IN)) ##1 (MODE == 4'h8) [*4];
   endsequence
   sequence s_bad_setup;
      (PSEL && !PENABLE && bad_addr) ##1 (PSEL && PENABLE);
   endsequence
   property p_mode_onehot; $onehot(MODE); endproperty
   property p_pin_idle; (MODE != 4'h4 && $past(MODE) != 4'h4) |-> (XCK_OE_N && !XCK_OUT); endproperty
   property p_pin_master; (master3 && $past(MODE) == 4'h4) |-> !XCK_OE_N; endproperty
   property p_master_edge; (s_master and $changed(XCK_OUT)) |-> (TX_TICK != RX_TICK); endproperty
   property p_master_quiet; (s_master and $stable(XCK_OUT)) |-> !any_tick; endproperty
   // A mode switch may legally put the old mode's last tick right beside the new mode's first one.
   property p_tick_pulse; TX_TICK ##1 $stable(MODE) |-> !TX_TICK; endproperty
   property p_slave_tick;
      s_xck_edge |-> (any_tick || $past(any_tick) || $past(any_tick, 2) || $past(any_tick, 3));
   endproperty
   property p_slverr; s_bad_setup |-> PSLVERR; endproperty
   a_mode_onehot: assert property (p_mode_onehot) else $error("mode not one-hot");
   a_pin_idle: assert property (p_pin_idle) else $error("pin active outside master");
   a_pin_master: assert property (p_pin_master) else $error("pin not driven in master");
   a_master_edge: assert property (p_master_edge) else $error("pin edge without one tick");
   a_master_quiet: assert property (p_master_quiet) else $error("tick without pin edge");
   a_tick_pulse: assert property (p_tick_pulse) else $error("transmit tick too long");
   a_slave_tick: assert property (p_slave_tick) else $error("slave edge gave no tick");
   a_slverr: assert property (p_slverr) else $error("unmapped access without error");
endmodule // ucg_asserts
bind ucg_clock_gen ucg_asserts i_ucg_asserts (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PADDR(PADDR), .PSLVERR(PSLVERR), .XCK_IN(XCK_IN), .XCK_OUT(XCK_OUT), .XCK_OE_N(XCK_OE_N),
   .MODE(MODE), .TX_TICK(TX_TICK), .RX_TICK(RX_TICK));
`default_nettype wire

// ---- bench/ucg_peer.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Remote synchronous peer driving the transfer clock pin
// ------------------------------------------------------------
module ucg_peer #(
   parameter int HALF = 4
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic en,
   output logic clk_out
);
   int cnt;
   // Half period of four system cycles keeps the rate at an eighth of the clock, well under a quarter.
   // When stopped the clock stands still at its last level.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cnt <= 0;
         clk_out <= 1'b0;
      end else if (en) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) clk_out <= ~clk_out;
      end
   end
endmodule // ucg_peer
`default_nettype wire

// ---- logic/ucg_clock_gen.v ----
// Functional notes
// - Exactly four clock modes: normal async, double async, sync master, sync slave.
// - Sync mode select zero means asynchronous, one means synchronous clocking.
// - In sync mode pin direction output means master, input means slave.
// - Transfer clock pin is neither driven nor used in asynchronous modes.
// - Down-counter runs at system clock, reloads at zero and on divisor low write.
// - One baud tick each time counter reaches zero, rate clock over divisor plus one.
// - Transmit clock is baud tick divided by 16, 8 or 2 in normal, double and master modes.
// - Baud divisor is 12 bits from high and low bytes, range 0 to 4095.
// - Double speed bit only affects asynchronous operation.
// - Double speed makes the receiver use 8 samples per bit, not 16.
// - Slave clock passes synchroniser then edge detector, two clock latency.
// - Internal clock for async and master; external clock only in slave mode.
// - Sync receive sampling uses the edge opposite to the transmit change edge.
// - Polarity clear: change on rising, sample on falling; set swaps them.
`timescale 1ns/1ps
`default_nettype none
`include "ucg_regs.vh"

module ucg_clock_gen (
   input wire CLOCK,
   input wire RST,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output reg PSLVERR,
   input wire XCK_IN,
   output wire XCK_OUT,
   output wire XCK_OE_N,
   output reg [3:0] MODE,
   output reg TX_TICK,
   output reg RX_TICK,
   output reg [3:0] RX_PHASE,
   output reg RX_LAST_PHASE
);

   // ------------------------------------------------------------------
   // Mode encodings
   // ------------------------------------------------------------------
   localparam [3:0] MODE_NORM = 4'b0001;
   localparam [3:0] MODE_DBL = 4'b0010;
   localparam [3:0] MODE_MASTER = 4'b0100;
   localparam [3:0] MODE_SLAVE = 4'b1000;

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   reg [3:0] ctrl_q;
   reg [3:0] div_high_q;
   reg [11:0] div_q;
   reg [11:0] cnt_q;
   reg [11:0] cnt_d;
   reg [3:0] pre_q;
   reg [3:0] pre_d;
   reg [3:0] phase_q;
   reg [3:0] phase_d;
   reg sync1_q;
   reg sync2_q;
   reg sync3_q;
   reg xck_q;
   reg xck_d;
   reg [3:0] mode_d;
   reg [3:0] tc;
   reg tx_d;
   reg rx_d;
   reg [31:0] rdata_d;
   reg err_d;
   wire sync_mode_select;
   wire double_speed_select;
   wire xfer_clock_pin_direction;
   wire sync_clock_polarity;
   wire wr_en;
   wire rd_en;
   wire low_wr;
   wire high_wr;
   wire ctrl_wr;
   wire baud_tick;
   wire xck_rise;
   wire xck_fall;
   wire int_rise;
   wire int_fall;
   wire chg_edge;
   wire smp_edge;
   wire [11:0] new_div;

   // ------------------------------------------------------------------
   // APB access decode
   // ------------------------------------------------------------------

   // The slave never inserts wait states, so every access ends in the
   // first access-phase cycle.
   assign PREADY = 1'b1;
   assign wr_en = PSEL & PENABLE & PWRITE;
   assign rd_en = PSEL & PENABLE & ~PWRITE;
   assign ctrl_wr = wr_en & (PADDR == `UCG_OFF_CTRL);
   assign low_wr = wr_en & (PADDR == `UCG_OFF_DIV_LOW);
   assign high_wr = wr_en & (PADDR == `UCG_OFF_DIV_HIGH);

   // Field aliases of the control register.
   assign sync_mode_select = ctrl_q[`UCG_CTRL_SYNC];
   assign double_speed_select = ctrl_q[`UCG_CTRL_DBL];
   assign xfer_clock_pin_direction = ctrl_q[`UCG_CTRL_DIR];
   assign sync_clock_polarity = ctrl_q[`UCG_CTRL_POL];

   // The full divisor as it will stand after a low-byte write this cycle.
   assign new_div = {div_high_q, PWDATA[`UCG_DIV_LOW_W-1:0]};

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------

   // The high byte is only held until the low byte is written, so a
   // divisor change lands atomically when the low half arrives.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctrl_q <= `UCG_RST_CTRL;
         div_high_q <= `UCG_RST_HIGH;
         div_q <= `UCG_RST_DIV;
      end else begin
         if (ctrl_wr) begin
            ctrl_q <= PWDATA[`UCG_CTRL_W-1:0];
         end
         if (high_wr) begin
            div_high_q <= PWDATA[`UCG_DIV_HIGH_W-1:0];
         end
         if (low_wr) begin
            div_q <= new_div;
         end
      end
   end

   // Read mux and error answer; unmapped addresses read zero with an error.
   always @* begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      case (PADDR)
         `UCG_OFF_CTRL: begin
            rdata_d[`UCG_CTRL_W-1:0] = ctrl_q;
         end
         `UCG_OFF_DIV_LOW: begin
            rdata_d[`UCG_DIV_LOW_W-1:0] = div_q[`UCG_DIV_LOW_W-1:0];
         end
         `UCG_OFF_DIV_HIGH: begin
            rdata_d[`UCG_DIV_HIGH_W-1:0] = div_high_q;
         end
         `UCG_OFF_STATUS: begin
            rdata_d[`UCG_STAT_MODE_LSB+3:`UCG_STAT_MODE_LSB] = MODE;
            rdata_d[`UCG_STAT_PIN] = sync2_q;
            rdata_d[`UCG_STAT_PHASE_LSB+3:`UCG_STAT_PHASE_LSB] = phase_q;
            rdata_d[`UCG_STAT_CNT_LSB+11:`UCG_STAT_CNT_LSB] = cnt_q;
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   // Read data and error are registered while the setup phase is seen, so
   // they are steady throughout the access phase.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (PSEL & ~PENABLE) begin
         PRDATA <= PWRITE ? 32'h0000_0000 : rdata_d;
         PSLVERR <= err_d;
      end else if (~PSEL) begin
         PSLVERR <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------------

   // The double speed bit is looked at only on the asynchronous branch,
   // which is also why a stray setting in sync mode does no harm.
   always @* begin
      if (!sync_mode_select) begin
         mode_d = double_speed_select ? MODE_DBL : MODE_NORM;
      end else if (xfer_clock_pin_direction) begin
         mode_d = MODE_MASTER;
      end else begin
         mode_d = MODE_SLAVE;
      end
   end

   // Divider terminal count for the transmit prescaler and receiver phase.
   always @* begin
      case (mode_d)
         MODE_NORM: tc = `UCG_TC_NORM;
         MODE_DBL: tc = `UCG_TC_DBL;
         MODE_MASTER: tc = `UCG_TC_SYNC;
         MODE_SLAVE: tc = `UCG_TC_SYNC;
         default: tc = `UCG_TC_NORM;
      endcase
   end

   // ------------------------------------------------------------------
   // Baud rate generator
   // ------------------------------------------------------------------

   // A tick fires in every cycle the counter sits at zero, giving one tick
   // per divisor-plus-one system clocks.
   assign baud_tick = (cnt_q == `UCG_RST_DIV);

   // Reload on zero or on a low-byte write; otherwise count down.
   always @* begin
      if (low_wr) begin
         cnt_d = new_div;
      end else if (baud_tick) begin
         cnt_d = div_q;
      end else begin
         cnt_d = cnt_q - 12'h001;
      end
   end

   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         cnt_q <= `UCG_RST_DIV;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // ------------------------------------------------------------------
   // Transmit prescaler and receiver phase
   // ------------------------------------------------------------------

   // Both count baud ticks; after a mode change a count above the new
   // terminal value wraps to zero at the next tick instead of running on.
   always @* begin
      pre_d = pre_q;
      phase_d = phase_q;
      if (baud_tick) begin
         pre_d = (pre_q >= tc) ? `UCG_PRE_RST : pre_q + 4'h1;
         phase_d = (phase_q >= tc) ? `UCG_PRE_RST : phase_q + 4'h1;
      end
   end

   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         pre_q <= `UCG_PRE_RST;
         phase_q <= `UCG_PRE_RST;
      end else begin
         pre_q <= pre_d;
         phase_q <= phase_d;
      end
   end

   // ------------------------------------------------------------------
   // Transfer clock pin
   // ------------------------------------------------------------------

   // Two-stage synchroniser; only the second stage feeds any logic.
   // The third flop is the edge detector's history.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
      end else begin
         sync1_q <= XCK_IN;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // The edge detector adds no cycle of latency of its own; the peer must
   // stay below a quarter of CLOCK or edges merge.
   assign xck_rise = sync2_q & ~sync3_q;
   assign xck_fall = ~sync2_q & sync3_q;

   // Master clock toggles on each baud tick, one transfer clock period
   // per two ticks; it parks low outside master mode.
   always @* begin
      xck_d = 1'b0;
      if (mode_d == MODE_MASTER) begin
         xck_d = baud_tick ? ~xck_q : xck_q;
      end
   end

   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         xck_q <= 1'b0;
      end else begin
         xck_q <= xck_d;
      end
   end

   // Pin is driven only in master mode, released otherwise.
   assign XCK_OUT = xck_q;
   assign XCK_OE_N = ~(MODE == MODE_MASTER);

   // Edges the master is about to make on its own clock.
   assign int_rise = baud_tick & ~xck_q & (mode_d == MODE_MASTER);
   assign int_fall = baud_tick & xck_q & (mode_d == MODE_MASTER);

   // Change and sample edges are always opposite; polarity picks which.
   assign chg_edge = sync_clock_polarity ?
      (int_fall | (xck_fall & (mode_d == MODE_SLAVE))) :
      (int_rise | (xck_rise & (mode_d == MODE_SLAVE)));
   assign smp_edge = sync_clock_polarity ?
      (int_rise | (xck_rise & (mode_d == MODE_SLAVE))) :
      (int_fall | (xck_fall & (mode_d == MODE_SLAVE)));

   // ------------------------------------------------------------------
   // Tick selection
   // ------------------------------------------------------------------

   // Asynchronous modes use the internal generator; the pin is ignored.
   always @* begin
      tx_d = 1'b0;
      rx_d = 1'b0;
      case (mode_d)
         MODE_NORM, MODE_DBL: begin
            tx_d = baud_tick & (pre_q >= tc);
            rx_d = baud_tick;
         end
         MODE_MASTER: begin
            tx_d = chg_edge;
            rx_d = smp_edge;
         end
         MODE_SLAVE: begin
            tx_d = chg_edge;
            rx_d = smp_edge;
         end
         default: begin
            tx_d = 1'b0;
            rx_d = 1'b0;
         end
      endcase
   end

   // Outputs are registered, one cycle behind the generating event.
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         MODE <= MODE_NORM;
         TX_TICK <= 1'b0;
         RX_TICK <= 1'b0;
         RX_PHASE <= `UCG_PRE_RST;
         RX_LAST_PHASE <= 1'b0;
      end else begin
         MODE <= mode_d;
         TX_TICK <= tx_d;
         RX_TICK <= rx_d;
         RX_PHASE <= phase_q;
         RX_LAST_PHASE <= baud_tick & (phase_q >= tc);
      end
   end

endmodule // ucg_clock_gen
`default_nettype wire

// ---- logic/ucg_regs.vh ----
`ifndef UCG_REGS_VH
`define UCG_REGS_VH

// ---------------------------------------------------------------------
// Register offsets (byte addresses on the APB bus)
// ---------------------------------------------------------------------
`define UCG_OFF_CTRL 12'h000
`define UCG_OFF_DIV_LOW 12'h004
`define UCG_OFF_DIV_HIGH 12'h008
`define UCG_OFF_STATUS 12'h00c

// ---------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------
`define UCG_CTRL_SYNC 0
`define UCG_CTRL_DBL 1
`define UCG_CTRL_DIR 2
`define UCG_CTRL_POL 3
`define UCG_CTRL_W 4
`define UCG_RST_CTRL 4'h0

// ---------------------------------------------------------------------
// Divisor fields and reset values
// ---------------------------------------------------------------------
`define UCG_DIV_W 12
`define UCG_DIV_LOW_W 8
`define UCG_DIV_HIGH_W 4
`define UCG_RST_DIV 12'h000
`define UCG_RST_HIGH 4'h0

// ---------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------
`define UCG_STAT_MODE_LSB 0
`define UCG_STAT_PIN 4
`define UCG_STAT_PHASE_LSB 8
`define UCG_STAT_CNT_LSB 16

// ---------------------------------------------------------------------
// Divider terminal counts (ratio minus one)
// ---------------------------------------------------------------------
`define UCG_TC_NORM 4'hf
`define UCG_TC_DBL 4'h7
`define UCG_TC_SYNC 4'h1
`define UCG_PRE_RST 4'h0

`endif
